/* inc/ppl_pkg.sv */
// Register map, port layout and operation codes of the port latch and pull-up block
package ppl_pkg;

    // ********************************************************************
    // Port layout
    // ********************************************************************
    localparam int NUM_PORTS = 4;
    localparam int PORT_BITS = 8;
    localparam int P0_W = 4;
    localparam int P1_W = 8;
    localparam int P3_W = 4;
    localparam int P12_W = 1;
    localparam logic [7:0] PORT_MASK [NUM_PORTS] = '{8'h0F, 8'hFF, 8'h0F, 8'h01};

    // ********************************************************************
    // Register addresses, index 0..3 = port zero, one, three, twelve
    // ********************************************************************
    localparam logic [15:0] ADDR_LATCH [NUM_PORTS] = '{16'hFF00, 16'hFF01, 16'hFF03, 16'hFF0C};
    localparam logic [15:0] ADDR_DIR [NUM_PORTS] = '{16'hFF20, 16'hFF21, 16'hFF23, 16'hFF2C};
    // pullup_select_port_zero, _one, _three, _twelve
    localparam logic [15:0] ADDR_PULLUP [NUM_PORTS] = '{16'hFF30, 16'hFF31, 16'hFF33, 16'hFF3C};

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [1:0] {
        KIND_NONE = 2'h0,
        KIND_LATCH = 2'h1,
        KIND_DIR = 2'h2,
        KIND_PULLUP = 2'h3
    } ppl_kind_type;

    typedef enum logic [2:0] {
        OP_WRITE = 3'h0,
        OP_AND = 3'h1,
        OP_OR = 3'h2,
        OP_XOR = 3'h3,
        OP_BSET = 3'h4,
        OP_BCLR = 3'h5,
        OP_BNOT = 3'h6
    } ppl_op_type;

endpackage : ppl_pkg

/* rtl/ppl_alu.sv */
// Byte operation unit for writes and read-modify-write accesses
`timescale 1ns/1ps
module ppl_alu
    import ppl_pkg::*;
(
    input wire ppl_pkg::ppl_op_type op, // Operation code
    input wire logic [7:0] operand,     // Current register or pin value
    input wire logic [7:0] wdata,       // Data from processor
    input wire logic [2:0] bit_sel,     // Bit number for bit operations
    output logic [7:0] result           // Whole byte to store
);
    logic [7:0] bit_mask;

    always_comb begin
        bit_mask = 8'h01 << bit_sel;
        unique case (op)
            OP_WRITE: result = wdata;
            OP_AND: result = operand & wdata;
            OP_OR: result = operand | wdata;
            OP_XOR: result = operand ^ wdata;
            OP_BSET: result = operand | bit_mask;
            OP_BCLR: result = operand & ~bit_mask;
            OP_BNOT: result = operand ^ bit_mask;
            default: result = wdata;
        endcase
    end

endmodule : ppl_alu

/* rtl/ppl_port_pullup_latch.sv */
// Port output latches, direction and pull-up select registers with pin control
`timescale 1ns/1ps

// Functional notes
// - Pull-up on only when selected and input
// - Output or alternate output disables pull-up
// - Select 1 connects; missing bits read zero
// - Reset clears all pull-up selects
// - Pull-up selects accept bit and byte writes
// - Bit operation acts on whole port byte
// - Output mode drives latch onto pin unless alternate output selected
// - Latch holds until next write
// - Reset clears output latches
// - Input mode write updates latch, pin unchanged
// - Output mode read returns latch
// - Input mode read returns synced pin
// - Output mode RMW uses latch operand
// - Input mode RMW uses pin operand
// - Direction 0 output, 1 input
// - Reset sets all direction bits
module ppl_port_pullup_latch
    import ppl_pkg::*;
(
    input wire logic REF_CLK,                 // System clock, 40 MHz
    input wire logic RST,                     // Synchronous reset, high
    input wire logic [15:0] ADDR,             // Register address
    input wire logic WR_STB,                  // Write or read-modify-write strobe
    input wire ppl_pkg::ppl_op_type OP,       // Operation for WR_STB
    input wire logic [2:0] BIT_SEL,           // Bit number for bit operations
    input wire logic [7:0] WDATA,             // Write data
    input wire logic RD_STB,                  // Read strobe
    output logic [7:0] RDATA,                 // Read data, registered
    output logic RVALID,                      // Read data valid pulse
    input wire logic [ppl_pkg::P0_W-1:0] P0_IN,        // Port zero pin levels
    output logic [ppl_pkg::P0_W-1:0] P0_OUT,           // Port zero pin drive value
    output logic [ppl_pkg::P0_W-1:0] P0_OE,            // Port zero driver enable
    output logic [ppl_pkg::P0_W-1:0] P0_PU,            // Port zero pull-up connect
    input wire logic [ppl_pkg::P0_W-1:0] P0_ALT_EN,    // Port zero alternate output select
    input wire logic [ppl_pkg::P0_W-1:0] P0_ALT_DATA,  // Port zero alternate output data
    input wire logic [ppl_pkg::P1_W-1:0] P1_IN,        // Port one pin levels
    output logic [ppl_pkg::P1_W-1:0] P1_OUT,           // Port one pin drive value
    output logic [ppl_pkg::P1_W-1:0] P1_OE,            // Port one driver enable
    output logic [ppl_pkg::P1_W-1:0] P1_PU,            // Port one pull-up connect
    input wire logic [ppl_pkg::P1_W-1:0] P1_ALT_EN,    // Port one alternate output select
    input wire logic [ppl_pkg::P1_W-1:0] P1_ALT_DATA,  // Port one alternate output data
    input wire logic [ppl_pkg::P3_W-1:0] P3_IN,        // Port three pin levels
    output logic [ppl_pkg::P3_W-1:0] P3_OUT,           // Port three pin drive value
    output logic [ppl_pkg::P3_W-1:0] P3_OE,            // Port three driver enable
    output logic [ppl_pkg::P3_W-1:0] P3_PU,            // Port three pull-up connect
    input wire logic [ppl_pkg::P3_W-1:0] P3_ALT_EN,    // Port three alternate output select
    input wire logic [ppl_pkg::P3_W-1:0] P3_ALT_DATA,  // Port three alternate output data
    input wire logic [ppl_pkg::P12_W-1:0] P12_IN,      // Port twelve pin level
    output logic [ppl_pkg::P12_W-1:0] P12_OUT,         // Port twelve pin drive value
    output logic [ppl_pkg::P12_W-1:0] P12_OE,          // Port twelve driver enable
    output logic [ppl_pkg::P12_W-1:0] P12_PU,          // Port twelve pull-up connect
    input wire logic [ppl_pkg::P12_W-1:0] P12_ALT_EN,  // Port twelve alternate output select
    input wire logic [ppl_pkg::P12_W-1:0] P12_ALT_DATA // Port twelve alternate output data
);
    import ppl_pkg::*;

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        logic [NUM_PORTS-1:0][PORT_BITS-1:0] lat;
        logic [NUM_PORTS-1:0][PORT_BITS-1:0] dir;
        logic [NUM_PORTS-1:0][PORT_BITS-1:0] pu;
        logic [7:0] rdata;
        logic rvalid;
    } ppl_state_type;

    localparam ppl_state_type RESET_STATE = '{
        lat: {NUM_PORTS{LATCH_RST}},
        dir: {NUM_PORTS{DIR_RST}},
        pu: {NUM_PORTS{PULLUP_RST}},
        rdata: RDATA_RST,
        rvalid: 1'h0
    };

    ppl_state_type state_ff;
    ppl_state_type nxt_state;

    // ********************************************************************
    // Pin gathering, padded to one byte per port
    // ********************************************************************
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] pin_raw;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] pin_sync;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] alt_en;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] alt_data;

    assign pin_raw[0][P0_W-1:0] = P0_IN;
    assign pin_raw[0][PORT_BITS-1:P0_W] = '0;
    assign pin_raw[1] = P1_IN;
    assign pin_raw[2][P3_W-1:0] = P3_IN;
    assign pin_raw[2][PORT_BITS-1:P3_W] = '0;
    assign pin_raw[3][P12_W-1:0] = P12_IN;
    assign pin_raw[3][PORT_BITS-1:P12_W] = '0;

    assign alt_en[0][P0_W-1:0] = P0_ALT_EN;
    assign alt_en[0][PORT_BITS-1:P0_W] = '0;
    assign alt_en[1] = P1_ALT_EN;
    assign alt_en[2][P3_W-1:0] = P3_ALT_EN;
    assign alt_en[2][PORT_BITS-1:P3_W] = '0;
    assign alt_en[3][P12_W-1:0] = P12_ALT_EN;
    assign alt_en[3][PORT_BITS-1:P12_W] = '0;

    assign alt_data[0][P0_W-1:0] = P0_ALT_DATA;
    assign alt_data[0][PORT_BITS-1:P0_W] = '0;
    assign alt_data[1] = P1_ALT_DATA;
    assign alt_data[2][P3_W-1:0] = P3_ALT_DATA;
    assign alt_data[2][PORT_BITS-1:P3_W] = '0;
    assign alt_data[3][P12_W-1:0] = P12_ALT_DATA;
    assign alt_data[3][PORT_BITS-1:P12_W] = '0;

    // Pins cross into the clock domain before any read sees them
    ppl_sync #(
        .WIDTH(NUM_PORTS * PORT_BITS)
    ) u_sync (
        .REF_CLK(REF_CLK),
        .RST(RST),
        .d_async(pin_raw),
        .q(pin_sync)
    );

    // ********************************************************************
    // Per-port read values and pin control
    // ********************************************************************
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] rd_lat;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] rd_dir;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] rd_pu;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] drv_out;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] drv_oe;
    logic [NUM_PORTS-1:0][PORT_BITS-1:0] drv_pu;

    genvar k;
    generate
        for (k = 0; k < NUM_PORTS; k++) begin : g_port
            // Input bits show the pin, output bits show the latch
            assign rd_lat[k] = ((state_ff.dir[k] & pin_sync[k])
                              | (~state_ff.dir[k] & state_ff.lat[k])) & PORT_MASK[k];
            // Missing direction bits read as one
            assign rd_dir[k] = state_ff.dir[k] | ~PORT_MASK[k];
            assign rd_pu[k] = state_ff.pu[k] & PORT_MASK[k];
            // Driver on only in output mode; latch drives unless alternate output
            assign drv_oe[k] = ~state_ff.dir[k] & PORT_MASK[k];
            assign drv_out[k] = ((alt_en[k] & alt_data[k])
                               | (~alt_en[k] & state_ff.lat[k])) & PORT_MASK[k];
            assign drv_pu[k] = state_ff.pu[k] & state_ff.dir[k] & ~alt_en[k] & PORT_MASK[k];
        end
    endgenerate

    // ********************************************************************
    // Address decode
    // ********************************************************************
    ppl_kind_type hit_kind;
    logic [1:0] hit_idx;
    logic [7:0] sel_read;
    logic [7:0] sel_mask;

    always_comb begin
        hit_kind = KIND_NONE;
        hit_idx = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (ADDR == ADDR_LATCH[i]) begin
                hit_kind = KIND_LATCH;
                hit_idx = 2'(i);
            end
            if (ADDR == ADDR_DIR[i]) begin
                hit_kind = KIND_DIR;
                hit_idx = 2'(i);
            end
            if (ADDR == ADDR_PULLUP[i]) begin
                hit_kind = KIND_PULLUP;
                hit_idx = 2'(i);
            end
        end
    end

    always_comb begin
        sel_mask = PORT_MASK[hit_idx];
        unique case (hit_kind)
            KIND_LATCH: sel_read = rd_lat[hit_idx];
            KIND_DIR: sel_read = rd_dir[hit_idx];
            KIND_PULLUP: sel_read = rd_pu[hit_idx];
            KIND_NONE: sel_read = UNMAPPED_READ;
        endcase
    end

    // ********************************************************************
    // Operation unit: the read value is the operand of every access
    // ********************************************************************
    logic [7:0] alu_result;

    ppl_alu u_alu (
        .op(OP),
        .operand(sel_read),
        .wdata(WDATA),
        .bit_sel(BIT_SEL),
        .result(alu_result)
    );

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = 1'h0;
        if (RD_STB) begin
            nxt_state.rdata = sel_read;
            nxt_state.rvalid = 1'h1;
        end
        if (WR_STB) begin
            unique case (hit_kind)
                // Whole byte stored, also for a bit operation
                KIND_LATCH: nxt_state.lat[hit_idx] = alu_result & sel_mask;
                KIND_DIR: nxt_state.dir[hit_idx] = alu_result | ~sel_mask;
                KIND_PULLUP: nxt_state.pu[hit_idx] = alu_result & sel_mask;
                KIND_NONE: nxt_state.rvalid = nxt_state.rvalid;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_ff <= RESET_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign RDATA = state_ff.rdata;
    assign RVALID = state_ff.rvalid;

    assign P0_OUT = drv_out[0][P0_W-1:0];
    assign P0_OE = drv_oe[0][P0_W-1:0];
    assign P0_PU = drv_pu[0][P0_W-1:0];
    assign P1_OUT = drv_out[1];
    assign P1_OE = drv_oe[1];
    assign P1_PU = drv_pu[1];
    assign P3_OUT = drv_out[2][P3_W-1:0];
    assign P3_OE = drv_oe[2][P3_W-1:0];
    assign P3_PU = drv_pu[2][P3_W-1:0];
    assign P12_OUT = drv_out[3][P12_W-1:0];
    assign P12_OE = drv_oe[3][P12_W-1:0];
    assign P12_PU = drv_pu[3][P12_W-1:0];

endmodule : ppl_port_pullup_latch

/* rtl/ppl_sync.sv */
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module ppl_sync #(
    parameter int WIDTH = 32
) (
    input wire logic REF_CLK,             // System clock
    input wire logic RST,                 // Synchronous reset, high
    input wire logic [WIDTH-1:0] d_async, // Raw pin levels
    output logic [WIDTH-1:0] q            // Synchronised levels
);
    typedef struct packed {
        logic [WIDTH-1:0] meta_ff;
        logic [WIDTH-1:0] sync_ff;
    } ppl_sync_state_type;

    ppl_sync_state_type state_ff;
    ppl_sync_state_type nxt_state;

    always_comb begin
        nxt_state.meta_ff = d_async;
        nxt_state.sync_ff = state_ff.meta_ff;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign q = state_ff.sync_ff;

endmodule : ppl_sync

/* testbench/ppl_assertions.sv */
// Concurrent checks on the port latch and pull-up block ports
`timescale 1ns/1ps
module ppl_assertions
    import ppl_pkg::*;
(
    input wire logic REF_CLK, // Clock
    input wire logic RST, // Reset
    input wire logic [15:0] ADDR, // Address
    input wire logic WR_STB, // Write strobe
    input wire ppl_pkg::ppl_op_type OP, // Operation
    input wire logic [7:0] WDATA, // Write data
    input wire logic RD_STB, // Read strobe
    input wire logic [7:0] RDATA, // Read data
    input wire logic RVALID, // Read valid
    input wire logic [7:0] P1_OUT, // Drive value
    input wire logic [7:0] P1_OE, // Driver enable
    input wire logic [7:0] P1_PU, // Pull-up connect
    input wire logic [7:0] P1_ALT_EN, // Alternate select
    input wire logic [7:0] P1_ALT_DATA // Alternate data
);
    // ****************************************************************
    // Port one and read channel
    // ****************************************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    sequence s_rd_req;
        RD_STB;
    endsequence
    sequence s_wr(a);
        WR_STB && OP == OP_WRITE && ADDR == a;
    endsequence

    a_read_latency: assert property (s_rd_req |=> RVALID)
        else $error("read valid missing");
    a_rvalid_cause: assert property (!RD_STB |=> !RVALID)
        else $error("read valid without request");
    a_reset_clean: assert property ($fell(RST) |-> RDATA == 8'h00 && !RVALID && P1_OE == 8'h00
        && P1_PU == 8'h00 && (P1_OUT & ~P1_ALT_EN) == 8'h00) else $error("state not cleared by reset");
    a_pu_blocked: assert property ((P1_PU & (P1_OE | P1_ALT_EN)) == 8'h00)
        else $error("pull-up on an output pin");
    a_alt_mux: assert property (((P1_OUT ^ P1_ALT_DATA) & P1_ALT_EN) == 8'h00)
        else $error("alternate data not driven");
    a_dir_write: assert property (s_wr(16'hFF21) |=> P1_OE == ~$past(WDATA))
        else $error("driver enable not from direction");
    a_latch_write: assert property (s_wr(16'hFF01) |=> ((P1_OUT ^ $past(WDATA)) & ~P1_ALT_EN) == 8'h00)
        else $error("latch write not on drive value");
    a_latch_hold: assert property (!(WR_STB && ADDR == 16'hFF01) |=>
        ((P1_OUT ^ $past(P1_OUT)) & ~P1_ALT_EN & ~$past(P1_ALT_EN)) == 8'h00) else $error("latch changed");
    a_pu_write: assert property (s_wr(16'hFF31) |=> P1_PU == ($past(WDATA) & ~P1_OE & ~P1_ALT_EN))
        else $error("pull-up connect wrong");
endmodule : ppl_assertions

bind ppl_port_pullup_latch ppl_assertions i_chk (.*);

/* testbench/ppl_pin_model.sv */
// Pin level model: own driver, external source, pull-up or floating
`timescale 1ns/1ps
module ppl_pin_model #(
    parameter int W = 17
) (
    input wire logic REF_CLK, // Clock
    input wire logic [W-1:0] OUT, // Drive value
    input wire logic [W-1:0] OE, // Driver enable
    input wire logic [W-1:0] PU, // Pull-up connect
    input wire logic [W-1:0] EXT_EN, // External source on
    input wire logic [W-1:0] EXT, // External level
    output logic [W-1:0] PIN // Resolved level
);
    logic [W-1:0] last_ff = '0;
    always_comb begin
        // Floating pin shows a changing level
        for (int i = 0; i < W; i++) begin
            PIN[i] = OE[i] ? OUT[i] : EXT_EN[i] ? EXT[i] : PU[i] ? 1'h1 : ~last_ff[i];
        end
    end
    always_ff @(posedge REF_CLK) begin
        last_ff <= PIN;
    end
endmodule : ppl_pin_model

/* testbench/tb_ppl_port_pullup_latch.sv */
// Self-checking testbench of the port latch and pull-up block
`timescale 1ns/1ps
module tb_ppl_port_pullup_latch;
    import ppl_pkg::*;
    logic REF_CLK = 1'h0;
    logic RST = 1'h1;
    logic [15:0] ADDR = 16'h0000;
    logic WR_STB = 1'h0;
    logic RD_STB = 1'h0;
    ppl_op_type OP = OP_WRITE;
    logic [2:0] BIT_SEL = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA;
    logic RVALID;
    logic [16:0] alt_en = 17'h00000;
    logic [16:0] alt_dat = 17'h00000;
    logic [16:0] ext_en = 17'h1F0FF;
    logic [16:0] ext = 17'h1A095;
    wire [16:0] pin, out, oe, pu;
    int n_errors = 0;
    int checks = 0;
    logic [7:0] lat;

    initial begin
        forever #12.5 REF_CLK = ~REF_CLK;
    end

    ppl_pin_model #(.W(17)) i_pins (.REF_CLK, .OUT(out), .OE(oe), .PU(pu), .EXT_EN(ext_en), .EXT(ext), .PIN(pin));

    ppl_port_pullup_latch i_dut (
        .REF_CLK, .RST, .ADDR, .WR_STB, .OP, .BIT_SEL, .WDATA, .RD_STB, .RDATA, .RVALID,
        .P0_IN(pin[3:0]), .P0_OUT(out[3:0]), .P0_OE(oe[3:0]), .P0_PU(pu[3:0]),
        .P0_ALT_EN(alt_en[3:0]), .P0_ALT_DATA(alt_dat[3:0]),
        .P1_IN(pin[11:4]), .P1_OUT(out[11:4]), .P1_OE(oe[11:4]), .P1_PU(pu[11:4]),
        .P1_ALT_EN(alt_en[11:4]), .P1_ALT_DATA(alt_dat[11:4]),
        .P3_IN(pin[15:12]), .P3_OUT(out[15:12]), .P3_OE(oe[15:12]), .P3_PU(pu[15:12]),
        .P3_ALT_EN(alt_en[15:12]), .P3_ALT_DATA(alt_dat[15:12]),
        .P12_IN(pin[16]), .P12_OUT(out[16]), .P12_OE(oe[16]), .P12_PU(pu[16]),
        .P12_ALT_EN(alt_en[16]), .P12_ALT_DATA(alt_dat[16])
    );

    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input ppl_op_type o, input logic [7:0] d, input logic [2:0] b);
        @(posedge REF_CLK);
        ADDR <= a;
        OP <= o;
        WDATA <= d;
        BIT_SEL <= b;
        WR_STB <= 1'h1;
        @(posedge REF_CLK);
        WR_STB <= 1'h0;
        #1;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge REF_CLK);
        ADDR <= a;
        RD_STB <= 1'h1;
        @(posedge REF_CLK);
        RD_STB <= 1'h0;
        #1;
        chk(RVALID, 1'h1);
        chk(RDATA, exp);
    endtask : rd

    function automatic logic [7:0] op_f(ppl_op_type o, logic [7:0] v, logic [7:0] d, logic [2:0] b);
        case (o)
            OP_AND: return v & d;
            OP_OR: return v | d;
            OP_XOR: return v ^ d;
            OP_BSET: return v | (8'h01 << b);
            OP_BCLR: return v & ~(8'h01 << b);
            OP_BNOT: return v ^ (8'h01 << b);
            default: return d;
        endcase
    endfunction : op_f

    task automatic close_out;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (5) @(posedge REF_CLK);
        RST <= 1'h0;
        @(posedge REF_CLK);
        for (int i = 0; i < NUM_PORTS; i++) begin
            rd(ADDR_PULLUP[i], PULLUP_RST);
            rd(ADDR_DIR[i], DIR_RST);
        end
        rd(ADDR_LATCH[0], 8'h05);
        rd(ADDR_LATCH[3], 8'h01);
        rd(16'hFF02, UNMAPPED_READ);
        for (int i = 0; i < NUM_PORTS; i++) begin
            wr(ADDR_PULLUP[i], OP_WRITE, 8'hFF, 3'h0);
            rd(ADDR_PULLUP[i], PORT_MASK[i]);
        end
        chk(pu, 17'h1FFFF);
        wr(ADDR_PULLUP[1], OP_BCLR, 8'h00, 3'h3);
        rd(ADDR_PULLUP[1], 8'hF7);
        wr(ADDR_DIR[1], OP_WRITE, 8'h0F, 3'h0);
        chk(oe, 17'h00F00);
        chk(pu, 17'h1F07F);
        @(posedge REF_CLK);
        alt_en <= 17'h00010;
        alt_dat <= 17'h00010;
        #1;
        chk(pu, 17'h1F06F);
        chk(out[4], 1'h1);
        @(posedge REF_CLK);
        alt_en <= 17'h00000;
        wr(ADDR_LATCH[1], OP_WRITE, 8'h55, 3'h0);
        chk(out[11:4], 8'h55);
        chk(pin[11:4], 8'h59);
        chk(oe, 17'h00F00);
        rd(ADDR_LATCH[1], 8'h59);
        lat = 8'h55;
        for (int k = 1; k < 7; k++) begin
            lat = op_f(ppl_op_type'(k), (lat & 8'hF0) | 8'h09, 8'h3C, k[2:0]);
            wr(ADDR_LATCH[1], ppl_op_type'(k), 8'h3C, k[2:0]);
            chk(out[11:4], lat);
            rd(ADDR_LATCH[1], (lat & 8'hF0) | 8'h09);
        end
        wr(ADDR_PULLUP[1], OP_WRITE, 8'h00, 3'h0);
        chk(out[11:4], lat);
        @(posedge REF_CLK);
        RST <= 1'h1;
        repeat (2) @(posedge REF_CLK);
        RST <= 1'h0;
        #1;
        chk(out, 17'h00000);
        chk(oe, 17'h00000);
        chk(pu, 17'h00000);
        @(posedge REF_CLK);
        rd(ADDR_PULLUP[0], PULLUP_RST);
        rd(ADDR_DIR[1], DIR_RST);
        close_out();
    end
endmodule : tb_ppl_port_pullup_latch
